/* src/tsc_pkg.sv */
// Operation
// (RQ1) remote two filter bits 3-2: 00 off, 01 basic, 11 enhanced, 10 reserved
// (RQ2) remote one filter field bits 1-0 uses the same filter encoding
// (RQ3) reserved bits of filter, summary and channel status registers read 0
// (RQ4) any write to trigger starts one pass, but only while standby is one
// (RQ5) trigger register is write-only; written byte is discarded, never stored
// (RQ6) summary bit 7 reads one while a conversion is running
// (RQ7) summary bit 6 reads one during the roughly 30 ms power-up sequence
// (RQ8) summary bits 3..0 are the OR of channel status registers 4..1
// (RQ9) fault bits: 3 r2 open, 2 r2 short, 1 r1 open, 0 r1 short
// (RQ10) faulted remote reports 0 unsigned and -128 signed
// (RQ11) alarm asserts on any unmasked critical flag, releases when all clear
// (RQ12) crit flag sets at or above limit, clears below limit minus hysteresis
// (RQ13) standby stops free running; passes run only on trigger writes
// (RQ14) channels with conversion disabled are skipped in every pass
// (RQ15) mask bit one blocks that channel from the alarm; zero lets it through
// (RQ16) status and fault bits update at each channel's conversion completion
// (RQ17) host waits for not-ready to clear and polls busy after a trigger
package tsc_pkg;
  // core clock and power-up timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned NR_TIME_MS = 30;
  localparam int unsigned NR_CYCLES = NR_TIME_MS * (CLK_HZ / 1000);
  // register offsets
  localparam logic [7:0] ADDR_SUMMARY = 8'h02;
  localparam logic [7:0] ADDR_FILTER = 8'h06;
  localparam logic [7:0] ADDR_FAULT = 8'h07;
  localparam logic [7:0] ADDR_CRIT1 = 8'h08;
  localparam logic [7:0] ADDR_TRIGGER = 8'h0f;
  // field layouts and reset values
  localparam int FILTER_W = 4;
  localparam logic [3:0] FILTER_RST = 4'hf;
  localparam int FLT_R1_LSB = 0;
  localparam int FLT_R2_LSB = 2;
  localparam int SUM_BUSY_BIT = 7;
  localparam int SUM_NR_BIT = 6;
  localparam int SUM_S4_BIT = 3;
  localparam int SUM_S3_BIT = 2;
  localparam int SUM_S2_BIT = 1;
  localparam int SUM_S1_BIT = 0;
  // filter codes
  localparam logic [1:0] FILT_OFF = 2'h0;
  localparam logic [1:0] FILT_BASIC = 2'h1;
  localparam logic [1:0] FILT_RSVD = 2'h2;
  localparam logic [1:0] FILT_ENH = 2'h3;
  // channels: local, remote one, remote two
  localparam logic [1:0] NUM_CH = 2'h3;
  localparam logic [1:0] CH_LOCAL = 2'h0;
  localparam logic [1:0] CH_R1 = 2'h1;
  localparam logic [1:0] CH_R2 = 2'h2;
  // values reported for a faulted remote diode
  localparam logic [7:0] TEMP_FAULT_S = 8'h80;
  localparam logic [7:0] TEMP_ZERO_U = 8'h00;
  // bus slave
  localparam logic [6:0] SMB_ADDR = 7'h2b; // arbitrary
  localparam logic [3:0] BYTE_BITS = 4'h8;
  typedef enum logic [3:0] {
    SMB_IDLE, SMB_DADDR, SMB_AACK, SMB_CMD, SMB_CACK,
    SMB_WDATA, SMB_WACK, SMB_RDATA, SMB_RACK
  } tsc_smb_state_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SCAN, SEQ_WAIT} tsc_seq_state_t;
endpackage : tsc_pkg

/* src/tsc_reg_if.sv */
`timescale 1ns/1ps
// toggle handshake between bus link domain and core domain
interface tsc_reg_if;
  logic req_tgl;
  logic req_wr;
  logic [7:0] req_addr;
  logic [7:0] req_wdata;
  logic ack_tgl;
  logic [7:0] rdata;
  modport link (output req_tgl, req_wr, req_addr, req_wdata,
                input ack_tgl, rdata);
  modport core (input req_tgl, req_wr, req_addr, req_wdata,
                output ack_tgl, rdata);
endinterface : tsc_reg_if

/* src/tsc_smb_slave.sv */
`timescale 1ns/1ps
module tsc_smb_slave #(
  parameter logic [6:0] DEV_ADDR = tsc_pkg::SMB_ADDR
) (
  // link clock and reset
  input wire logic smb_clk,
  input wire logic rst_n,
  // bus pins, data is open drain
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_oe,
  // register requests toward the core
  tsc_reg_if.link rq
);
  import tsc_pkg::*;
  logic [1:0] scl_sync, sda_sync, ack_sync;
  logic scl_prev, sda_prev, ack_prev;
  tsc_smb_state_t state, next_state;
  logic [3:0] bitcnt, next_bitcnt;
  logic [7:0] shreg, next_shreg, cmd, next_cmd, rbyte, next_rbyte;
  logic rd_mode, next_rd_mode, oe, next_oe;
  logic req_tgl, next_req_tgl, req_wr, next_req_wr;
  logic [7:0] req_addr, next_req_addr, req_wdata, next_req_wdata;
  logic scl_rise, scl_fall, start_c, stop_c;

  // edges seen only after two synchroniser stages
  assign scl_rise = scl_sync[1] & ~scl_prev;
  assign scl_fall = ~scl_sync[1] & scl_prev;
  assign start_c = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
  assign stop_c = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];
  assign sda_oe = oe;
  assign rq.req_tgl = req_tgl;
  assign rq.req_wr = req_wr;
  assign rq.req_addr = req_addr;
  assign rq.req_wdata = req_wdata;

  // byte engine: sample on rising scl, change data on falling scl
  always_comb begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_cmd = cmd;
    next_rd_mode = rd_mode;
    next_oe = oe;
    next_req_tgl = req_tgl;
    next_req_wr = req_wr;
    next_req_addr = req_addr;
    next_req_wdata = req_wdata;
    next_rbyte = (ack_sync[1] != ack_prev) ? rq.rdata : rbyte;
    if (start_c) begin
      next_state = SMB_DADDR;
      next_bitcnt = '0;
      next_oe = 1'b0;
    end else if (stop_c) begin
      next_state = SMB_IDLE;
      next_oe = 1'b0;
    end else begin
      unique case (state)
        SMB_IDLE: ;
        SMB_DADDR, SMB_CMD, SMB_WDATA: begin
          if (scl_rise && bitcnt < BYTE_BITS) begin
            next_shreg = {shreg[6:0], sda_sync[1]};
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == BYTE_BITS) begin
            next_bitcnt = '0;
            next_oe = 1'b1;
            if (state == SMB_DADDR) begin
              next_rd_mode = shreg[0];
              next_state = SMB_AACK;
              if (shreg[7:1] != DEV_ADDR) begin
                next_state = SMB_IDLE;
                next_oe = 1'b0;
              end
            end else if (state == SMB_CMD) begin
              // prefetch the addressed byte for a following read
              next_cmd = shreg;
              next_state = SMB_CACK;
              next_req_wr = 1'b0;
              next_req_addr = shreg;
              next_req_tgl = ~req_tgl;
            end else begin
              next_state = SMB_WACK;
              next_req_wr = 1'b1;
              next_req_addr = cmd;
              next_req_wdata = shreg;
              next_req_tgl = ~req_tgl;
            end
          end
        end
        SMB_AACK, SMB_CACK, SMB_WACK, SMB_RACK: begin
          if (state == SMB_RACK && scl_rise && sda_sync[1]) begin
            next_state = SMB_IDLE; // master refused more data
          end else if (scl_fall) begin
            if ((state == SMB_AACK && rd_mode) || state == SMB_RACK) begin
              next_state = SMB_RDATA;
              next_oe = ~rbyte[7];
              next_shreg = {rbyte[6:0], 1'b0};
              next_bitcnt = 4'h1;
            end else begin
              next_oe = 1'b0;
              next_state = (state == SMB_AACK) ? SMB_CMD : SMB_WDATA;
            end
          end
        end
        SMB_RDATA: begin
          if (scl_fall) begin
            if (bitcnt == BYTE_BITS) begin
              next_oe = 1'b0;
              next_state = SMB_RACK;
              next_bitcnt = '0;
            end else begin
              next_oe = ~shreg[7];
              next_shreg = {shreg[6:0], 1'b0};
              next_bitcnt = bitcnt + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // link domain registers
  always_ff @(posedge smb_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      ack_sync <= '0;
      ack_prev <= 1'b0;
      state <= SMB_IDLE;
      bitcnt <= '0;
      shreg <= '0;
      cmd <= '0;
      rbyte <= '0;
      rd_mode <= 1'b0;
      oe <= 1'b0;
      req_tgl <= 1'b0;
      req_wr <= 1'b0;
      req_addr <= '0;
      req_wdata <= '0;
    end else begin
      scl_sync <= {scl_sync[0], scl};
      sda_sync <= {sda_sync[0], sda_in};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
      ack_sync <= {ack_sync[0], rq.ack_tgl};
      ack_prev <= ack_sync[1];
      state <= next_state;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      cmd <= next_cmd;
      rbyte <= next_rbyte;
      rd_mode <= next_rd_mode;
      oe <= next_oe;
      req_tgl <= next_req_tgl;
      req_wr <= next_req_wr;
      req_addr <= next_req_addr;
      req_wdata <= next_req_wdata;
    end
  end
endmodule : tsc_smb_slave

/* src/tsc_status_ctrl.sv */
`timescale 1ns/1ps
module tsc_status_ctrl #(
  parameter int unsigned NR_CYC = tsc_pkg::NR_CYCLES
) (
  // core clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // bus link clock and pins
  input wire logic smb_clk,
  input wire logic smb_scl,
  input wire logic smb_sda_in,
  output logic smb_sda_out,
  output logic smb_sda_oe,
  // configuration held elsewhere on the same clock
  input wire logic standby_ctrl,
  input wire logic local_conv_en,
  input wire logic remote_one_conv_en,
  input wire logic remote_two_conv_en,
  input wire logic local_crit_block,
  input wire logic remote_one_crit_one_block,
  input wire logic remote_two_crit_one_block,
  input wire logic [tsc_pkg::NUM_CH-1:0][7:0] crit_one_limit,
  input wire logic [7:0] crit_hyst,
  input wire logic [2:0] crit_two_status,
  input wire logic [2:0] crit_three_status,
  // conversion engine
  output logic conv_req,
  output logic [1:0] conv_ch,
  input wire logic conv_done,
  input wire logic [7:0] conv_temp,
  input wire logic conv_open,
  input wire logic conv_short,
  // results
  output logic [tsc_pkg::NUM_CH-1:0][7:0] rep_temp_signed,
  output logic [tsc_pkg::NUM_CH-1:0][7:0] rep_temp_unsigned,
  output logic [1:0] remote_one_filter_sel,
  output logic [1:0] remote_two_filter_sel,
  output logic crit_alarm_one_out_n
);
  import tsc_pkg::*;
  localparam int NRW = $clog2(NR_CYC + 1);

  tsc_reg_if rq ();
  logic [2:0] req_sync, next_req_sync;
  logic [FILTER_W-1:0] filter, next_filter;
  logic ack_tgl, next_ack;
  logic [7:0] rdata, next_rdata, rd_word;
  logic req_new, trig_wr;
  tsc_seq_state_t seq, next_seq;
  logic [1:0] ch, next_ch;
  logic shot_pend, next_shot;
  logic next_req;
  logic [NRW-1:0] nr_cnt, next_nr_cnt;
  logic nr, busy;
  logic [2:0] crit, next_crit, conv_en, crit_mask;
  logic [3:0] fault, next_fault;
  logic [NUM_CH-1:0][7:0] next_rep_s, next_rep_u;
  logic next_alarm_n, faulted;
  logic [7:0] temp_s, lim;
  logic signed [9:0] t_ext, l_ext, f_ext;

  tsc_smb_slave u_slave (
    .smb_clk(smb_clk),
    .rst_n(rst_n),
    .scl(smb_scl),
    .sda_in(smb_sda_in),
    .sda_oe(smb_sda_oe),
    .rq(rq)
  );

  // open drain: the pin is only ever pulled low
  assign smb_sda_out = 1'b0;
  assign rq.ack_tgl = ack_tgl;
  assign rq.rdata = rdata;
  assign conv_en = {remote_two_conv_en, remote_one_conv_en, local_conv_en};
  assign crit_mask = {remote_two_crit_one_block, remote_one_crit_one_block,
                      local_crit_block};
  assign nr = (nr_cnt != '0);
  assign busy = (seq != SEQ_IDLE);
  assign remote_one_filter_sel = filter[FLT_R1_LSB +: 2]; // RQ2
  assign remote_two_filter_sel = filter[FLT_R2_LSB +: 2]; // RQ1
  // a new request is seen once the toggle has passed two stages
  assign req_new = req_sync[2] ^ req_sync[1];
  // trigger data is never looked at, only the write itself
  assign trig_wr = req_new && rq.req_wr && rq.req_addr == ADDR_TRIGGER
                   && standby_ctrl; // RQ4 RQ5

  // read mux; unlisted bits stay zero
  always_comb begin
    rd_word = '0;
    unique case (rq.req_addr)
      ADDR_SUMMARY: begin
        rd_word[SUM_BUSY_BIT] = busy; // RQ6
        rd_word[SUM_NR_BIT] = nr; // RQ7
        rd_word[SUM_S4_BIT] = |crit_three_status; // RQ8
        rd_word[SUM_S3_BIT] = |crit_two_status; // RQ8
        rd_word[SUM_S2_BIT] = |crit; // RQ8
        rd_word[SUM_S1_BIT] = |fault; // RQ8
      end
      ADDR_FILTER: rd_word[FILTER_W-1:0] = filter; // RQ3
      ADDR_FAULT: rd_word[3:0] = fault; // RQ9 RQ3
      ADDR_CRIT1: rd_word[2:0] = crit; // RQ3
      default: rd_word = '0;
    endcase
  end

  // request handling from the link domain
  always_comb begin
    next_req_sync = {req_sync[1:0], rq.req_tgl};
    next_filter = filter;
    next_ack = ack_tgl;
    next_rdata = rdata;
    if (req_new) begin
      next_ack = ~ack_tgl;
      if (!rq.req_wr) begin
        next_rdata = rd_word;
      end else if (rq.req_addr == ADDR_FILTER) begin
        // code 10 is stored as written; software must avoid it
        next_filter = rq.req_wdata[FILTER_W-1:0]; // RQ1 RQ2
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      req_sync <= '0;
      filter <= FILTER_RST;
      ack_tgl <= 1'b0;
      rdata <= '0;
    end else begin
      req_sync <= next_req_sync;
      filter <= next_filter;
      ack_tgl <= next_ack;
      rdata <= next_rdata;
    end
  end

  // value of the finished channel, forced while its diode is faulted
  always_comb begin
    faulted = (ch != CH_LOCAL) && (conv_open || conv_short);
    temp_s = faulted ? TEMP_FAULT_S : conv_temp; // RQ10
    lim = crit_one_limit[ch];
    t_ext = {{2{temp_s[7]}}, temp_s};
    l_ext = {{2{lim[7]}}, lim};
    f_ext = l_ext - {2'h0, crit_hyst};
  end

  // pass sequencer, status flags and alarm
  always_comb begin
    next_seq = seq;
    next_ch = ch;
    next_req = 1'b0;
    next_shot = shot_pend | trig_wr; // a new write wins over the clear
    next_nr_cnt = nr ? nr_cnt - 1'b1 : nr_cnt;
    next_crit = crit;
    next_fault = fault;
    next_rep_s = rep_temp_signed;
    next_rep_u = rep_temp_unsigned;
    unique case (seq)
      SEQ_IDLE: begin
        // standby holds off free running passes
        if (!nr && (!standby_ctrl || shot_pend)) begin // RQ13 RQ4
          next_seq = SEQ_SCAN;
          next_ch = '0;
          if (standby_ctrl) begin
            next_shot = trig_wr;
          end
        end
      end
      SEQ_SCAN: begin
        if (ch == NUM_CH) begin
          next_seq = SEQ_IDLE;
        end else if (conv_en[ch]) begin
          next_req = 1'b1;
          next_seq = SEQ_WAIT;
        end else begin
          next_ch = ch + 2'h1; // RQ14
        end
      end
      SEQ_WAIT: begin
        if (conv_done) begin
          // everything for this channel changes together
          next_rep_s[ch] = temp_s; // RQ16 RQ10
          next_rep_u[ch] = (faulted || conv_temp[7]) ? TEMP_ZERO_U
                                                      : conv_temp;
          if (t_ext >= l_ext) begin
            next_crit[ch] = 1'b1; // RQ12
          end else if (t_ext < f_ext) begin
            next_crit[ch] = 1'b0; // RQ12
          end
          if (ch == CH_R1) begin
            next_fault[FLT_R1_LSB +: 2] = {conv_open, conv_short}; // RQ9
          end else if (ch == CH_R2) begin
            next_fault[FLT_R2_LSB +: 2] = {conv_open, conv_short}; // RQ9
          end
          next_ch = ch + 2'h1;
          next_seq = SEQ_SCAN;
        end
      end
    endcase
    next_alarm_n = ~|(crit & ~crit_mask); // RQ11 RQ15
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seq <= SEQ_IDLE;
      ch <= '0;
      conv_req <= 1'b0;
      conv_ch <= '0;
      shot_pend <= 1'b0;
      nr_cnt <= NR_CYC[NRW-1:0];
      crit <= '0;
      fault <= '0;
      rep_temp_signed <= '0;
      rep_temp_unsigned <= '0;
      crit_alarm_one_out_n <= 1'b1;
    end else begin
      seq <= next_seq;
      ch <= next_ch;
      conv_req <= next_req;
      conv_ch <= (next_req) ? ch : conv_ch;
      shot_pend <= next_shot;
      nr_cnt <= next_nr_cnt;
      crit <= next_crit;
      fault <= next_fault;
      rep_temp_signed <= next_rep_s;
      rep_temp_unsigned <= next_rep_u;
      crit_alarm_one_out_n <= next_alarm_n;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_alarm_asserts: assert property ( // RQ11
    (|(crit & ~crit_mask)) |=> !crit_alarm_one_out_n)
    else $error("alarm not asserted for unmasked flag");
  chk_mask_blocks: assert property ( // RQ15
    ((crit & ~crit_mask) == 3'h0) |=> crit_alarm_one_out_n)
    else $error("alarm active with only masked flags");
  chk_crit_sets: assert property ( // RQ12
    (seq == SEQ_WAIT && conv_done && t_ext >= l_ext) |=> crit[$past(ch)])
    else $error("critical flag not set at limit");
  chk_crit_holds: assert property ( // RQ12
    (seq == SEQ_WAIT && conv_done && t_ext < l_ext && t_ext >= f_ext)
    |=> crit == $past(crit))
    else $error("critical flag moved inside hysteresis band");
  chk_skip_disabled: assert property ( // RQ14
    conv_req |-> conv_en[conv_ch] && seq == SEQ_WAIT)
    else $error("conversion issued for disabled channel");
  chk_standby_gate: assert property ( // RQ13
    ($rose(busy) && $past(standby_ctrl)) |-> $past(shot_pend))
    else $error("pass started in standby without trigger");
  chk_not_ready: assert property ( // RQ7
    nr |-> !busy && !conv_req)
    else $error("conversion while power-up not ready");
  chk_fault_value: assert property ( // RQ10
    (seq == SEQ_WAIT && conv_done && faulted)
    |=> rep_temp_signed[$past(ch)] == TEMP_FAULT_S
        && rep_temp_unsigned[$past(ch)] == TEMP_ZERO_U)
    else $error("faulted channel value not forced");
  chk_filter_rsvd: assert property ( // RQ3
    (req_new && !rq.req_wr && rq.req_addr == ADDR_FILTER)
    |=> rdata[7:FILTER_W] == '0 && rdata[FILTER_W-1:0] == $past(filter))
    else $error("filter read returns bad reserved bits");
  chk_busy_read: assert property ( // RQ6
    (req_new && !rq.req_wr && rq.req_addr == ADDR_SUMMARY)
    |=> rdata[SUM_BUSY_BIT] == $past(busy))
    else $error("summary busy bit wrong");
endmodule : tsc_status_ctrl

/* tb/tsc_conv_model.sv */
`timescale 1ns/1ps
// conversion engine stand-in: answers each request dly+1 cycles after taking it
module tsc_conv_model (
  // core clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // request from the sequencer
  input wire logic conv_req,
  input wire logic [1:0] conv_ch,
  // latency, readings and faults per channel
  input wire logic [15:0] dly,
  input wire logic [tsc_pkg::NUM_CH-1:0][7:0] temp,
  input wire logic [2:0] open_f,
  input wire logic [2:0] short_f,
  // result toward the block
  output logic conv_done,
  output logic [7:0] conv_temp,
  output logic conv_open,
  output logic conv_short
);
  import tsc_pkg::*;
  int cnt [3];
  int total;
  logic [15:0] left;
  logic busy;
  logic [1:0] ch;
  // one conversion outstanding; counts let the bench see which ran
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      ch <= 2'h0;
      left <= 16'h0000;
      conv_done <= 1'b0;
      total <= 0;
      cnt <= '{0, 0, 0};
    end else begin
      conv_done <= 1'b0;
      if (conv_req) begin
        busy <= 1'b1;
        ch <= conv_ch;
        left <= dly;
      end else if (busy && left != 16'h0000) begin
        left <= left - 16'h0001;
      end else if (busy) begin
        busy <= 1'b0;
        conv_done <= 1'b1;
        cnt[ch] <= cnt[ch] + 1;
        total <= total + 1;
      end
    end
  end
  // outside done the lines show the inverse, so a late sample is caught
  assign conv_temp = conv_done ? temp[ch] : ~temp[ch];
  assign conv_open = conv_done ? open_f[ch] : ~open_f[ch];
  assign conv_short = conv_done ? short_f[ch] : ~short_f[ch];
endmodule : tsc_conv_model

/* tb/tsc_status_ctrl_test.sv */
`timescale 1ns/1ps
module tsc_status_ctrl_test;
  import tsc_pkg::*;
  localparam int Q = 16; // quarter bus bit in core cycles
  localparam logic [7:0] TL [7] = '{8'h32, 8'h2e, 8'h2c, 8'h40, 8'h40,
                                    8'h2c, 8'h2c};
  localparam logic [7:0] TR [7] = '{8'h19, 8'h19, 8'h19, 8'h46, 8'h46,
                                    8'h46, 8'h36};
  localparam logic [6:0] ML = 7'h08;
  localparam logic [6:0] MR = 7'h1f;
  localparam logic [6:0] EN = 7'h4c;
  logic clock, smb_clk, rst_n, scl, sda_m, sda_out, sda_oe, sda, ack;
  logic standby_ctrl, local_conv_en, remote_one_conv_en, remote_two_conv_en;
  logic local_crit_block, remote_one_crit_one_block, remote_two_crit_one_block;
  logic [NUM_CH-1:0][7:0] crit_one_limit, rep_s, rep_u, temp;
  logic [7:0] crit_hyst, rd, conv_temp;
  logic [2:0] crit_two_status, crit_three_status, open_f, short_f;
  logic conv_req, conv_done, conv_open, conv_short, alarm_n;
  logic [1:0] conv_ch, f1_sel, f2_sel;
  logic [15:0] dly;
  int err_count, checks_done, base;
  int c [3];
  // open-drain data line with pull-up
  assign sda = sda_m & (sda_oe ? sda_out : 1'b1);
  tsc_status_ctrl #(.NR_CYC(3000)) dut (.clock, .rst_n, .smb_clk,
    .smb_scl(scl), .smb_sda_in(sda), .smb_sda_out(sda_out),
    .smb_sda_oe(sda_oe), .standby_ctrl, .local_conv_en, .remote_one_conv_en,
    .remote_two_conv_en, .local_crit_block, .remote_one_crit_one_block,
    .remote_two_crit_one_block, .crit_one_limit, .crit_hyst,
    .crit_two_status, .crit_three_status, .conv_req, .conv_ch, .conv_done,
    .conv_temp, .conv_open, .conv_short, .rep_temp_signed(rep_s),
    .rep_temp_unsigned(rep_u), .remote_one_filter_sel(f1_sel),
    .remote_two_filter_sel(f2_sel), .crit_alarm_one_out_n(alarm_n));
  tsc_conv_model m (.clock, .rst_n, .conv_req, .conv_ch, .dly, .temp,
    .open_f, .short_f, .conv_done, .conv_temp, .conv_open, .conv_short);
  // core clock, and a link clock unrelated in phase
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    smb_clk = 1'b0;
    #17;
    forever #62.5 smb_clk = ~smb_clk;
  end
  task finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  task chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : tick
  // bus bits: data moves only while the bus clock is low
  task bit_out(input logic b);
    sda_m = b;
    tick(Q);
    scl = 1'b1;
    tick(2 * Q);
    scl = 1'b0;
    tick(Q);
  endtask : bit_out
  task bit_in(output logic b);
    sda_m = 1'b1;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    b = sda;
    tick(Q);
    scl = 1'b0;
    tick(Q);
  endtask : bit_in
  task start_c();
    sda_m = 1'b1;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    sda_m = 1'b0;
    tick(Q);
    scl = 1'b0;
    tick(Q);
  endtask : start_c
  task stop_c();
    sda_m = 1'b0;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    sda_m = 1'b1;
    tick(Q);
  endtask : stop_c
  task send_byte(input logic [7:0] b, output logic a);
    logic x;
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
    bit_in(x);
    a = !x;
  endtask : send_byte
  task reg_wr(input logic [7:0] a, input logic [7:0] d);
    logic a0, a1, a2;
    start_c();
    send_byte({tsc_pkg::SMB_ADDR, 1'b0}, a0);
    send_byte(a, a1);
    send_byte(d, a2);
    stop_c();
    chk("write acks", {5'h00, a0, a1, a2}, 8'h07);
  endtask : reg_wr
  // read: command, repeated start, one byte ended by a not-ack
  task rd_chk(input string what, input logic [7:0] a, input logic [7:0] e);
    logic a0, a1, a2;
    start_c();
    send_byte({tsc_pkg::SMB_ADDR, 1'b0}, a0);
    send_byte(a, a1);
    start_c();
    send_byte({tsc_pkg::SMB_ADDR, 1'b1}, a2);
    for (int i = 7; i >= 0; i--) bit_in(rd[i]);
    bit_out(1'b1);
    stop_c();
    chk("read acks", {5'h00, a0, a1, a2}, 8'h07);
    chk(what, rd, e);
  endtask : rd_chk
  // bounded wait for n more conversions than base; running out is a mismatch
  task wait_conv(input int n);
    for (int i = 0; i < 40000 && m.total < base + n; i++) tick(1);
    if (m.total < base + n) begin
      err_count++;
      $display("BAD conversions exp %0d got %0d", base + n, m.total);
      finish_test();
    end
  endtask : wait_conv
  // trigger one pass and wait for n conversions to finish
  task pass_run(input int n);
    base = m.total;
    reg_wr(ADDR_TRIGGER, 8'h5a);
    wait_conv(n);
    tick(4);
  endtask : pass_run
  initial begin
    {rst_n, standby_ctrl, crit_two_status, crit_three_status} = 8'h00;
    {scl, sda_m, local_conv_en, remote_one_conv_en, remote_two_conv_en} = 5'h1f;
    {local_crit_block, remote_one_crit_one_block} = 2'h0;
    remote_two_crit_one_block = 1'b0;
    crit_one_limit = {8'h3c, 8'h7f, 8'h32};
    crit_hyst = 8'h05;
    temp = {3{8'h19}};
    {open_f, short_f} = 6'h00;
    dly = 16'h0003;
    err_count = 0;
    checks_done = 0;
    repeat (8) @(posedge clock);
    #2;
    rst_n = 1'b1;
    tick(20);
    rd_chk("summary", ADDR_SUMMARY, 8'h40);
    chk("early conversions", 8'(m.total), 8'h00);
    rd_chk("filter reset", ADDR_FILTER, 8'h0f);
    chk("filter sel", {4'h0, f2_sel, f1_sel}, 8'h0f);
    start_c();
    send_byte({tsc_pkg::SMB_ADDR ^ 7'h01, 1'b0}, ack);
    stop_c();
    chk("foreign ack", {7'h00, ack}, 8'h00);
    base = m.total;
    tick(200);
    chk("free running", 8'(m.total > base), 8'h01);
    standby_ctrl = 1'b1;
    tick(100);
    base = m.total;
    tick(300);
    chk("standby halt", 8'(m.total - base), 8'h00);
    rd_chk("summary", ADDR_SUMMARY, 8'h00);
    $display("test power-up done");
    for (int k = 0; k < 4; k++) begin
      reg_wr(ADDR_FILTER, {4'hf, 2'(k), 2'(3 - k)});
      rd_chk("filter", ADDR_FILTER, {4'h0, 2'(k), 2'(3 - k)});
      chk("filter sel", {4'h0, f2_sel, f1_sel},
          {4'h0, 2'(k), 2'(3 - k)});
    end
    $display("test filter done");
    dly = 16'h05dc;
    remote_one_conv_en = 1'b0;
    c = m.cnt;
    base = m.total;
    reg_wr(ADDR_TRIGGER, 8'ha5);
    rd_chk("summary busy", ADDR_SUMMARY, 8'h80);
    wait_conv(2);
    tick(200);
    chk("local runs", 8'(m.cnt[0] - c[0]), 8'h01);
    chk("remote one runs", 8'(m.cnt[1] - c[1]), 8'h00);
    chk("remote two runs", 8'(m.cnt[2] - c[2]), 8'h01);
    rd_chk("trigger", ADDR_TRIGGER, 8'h00);
    rd_chk("summary", ADDR_SUMMARY, 8'h00);
    $display("test trigger done");
    dly = 16'h0003;
    remote_one_conv_en = 1'b1;
    {open_f, short_f, crit_two_status} = 9'h0a2;
    pass_run(3);
    rd_chk("fault", ADDR_FAULT, 8'h06);
    rd_chk("summary", ADDR_SUMMARY, 8'h05);
    chk("r1 signed", rep_s[1], 8'h80);
    chk("r2 unsigned", rep_u[2], 8'h00);
    {open_f, short_f, crit_two_status, crit_three_status} = 12'h880;
    crit_three_status = 3'h1;
    pass_run(3);
    rd_chk("fault", ADDR_FAULT, 8'h09);
    rd_chk("summary", ADDR_SUMMARY, 8'h09);
    {open_f, short_f, crit_three_status} = 9'h000;
    pass_run(3);
    rd_chk("fault", ADDR_FAULT, 8'h00);
    chk("r1 signed", rep_s[1], 8'h19);
    $display("test fault done");
    for (int s = 0; s < 7; s++) begin
      temp[0] = TL[s];
      temp[2] = TR[s];
      local_crit_block = ML[s];
      remote_two_crit_one_block = MR[s];
      pass_run(3);
      chk("alarm", {7'h00, alarm_n}, {7'h00, EN[s]});
      if (s == 3) begin
        rd_chk("crit one", ADDR_CRIT1, 8'h05);
        rd_chk("summary", ADDR_SUMMARY, 8'h02);
      end
    end
    $display("test alarm done");
    finish_test();
  end
endmodule : tsc_status_ctrl_test
